// file: pkg/sfh_pkg.sv
// How it works
// R1: Read when select and drive low.
// R2: Device floats data when deselected.
// R3: Device latches address late, data early; the model latches address at strobe fall, data at strobe rise.
// R4: Each load pulses strobe, drive held high.
// R5: Unloaded bytes read back as ones.
// R6: Next load within 150 us of last.
// R7: Device starts programming after 150 us gap.
// R8: Upper bits sector, low eight byte position.
// R9: Same sector address on every load; host only drops req_ready on mismatch, IDLE ignores ready.
// R10: Byte positions may load in any order.
// R11: Reads poll during program cycle.
// R12: Device erases sector then writes bytes.
// R13: Device latches sector; bus freed meanwhile.
// R14: Protection off when delivered.
// R15: Three fixed commands switch protection on.
// R16: Protected writes need the three-command prefix.
// R17: Command bytes use load timing limits.
// R18: Protection covers all sectors, persists.
// R19: Unprefixed protected write still times out.
// R20: Program refused with drive low, deselected.
// R21: Short strobe pulses are ignored.
// R22: No programming for 5 ms after power-up.
// R23: Identity codes same by both methods.
// R24: Poll line shows inverted bit seven.
// R25: Toggle line flips each read while busy.
// R26: Command addresses and data are constants.
package sfh_pkg;
  localparam int unsigned CLK_MHZ = 100;
  // Strobe phase timing (ns), load gap (us), power-up wait (ms), derived cycles
  localparam int unsigned T_SETUP_NS  = 30;
  localparam int unsigned T_PULSE_NS  = 100;
  localparam int unsigned T_READ_NS   = 120;
  localparam int unsigned T_GAP_US    = 150;
  localparam int unsigned T_PWRUP_MS  = 5;
  localparam logic [7:0] SETUP_CYC = 8'((T_SETUP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] PULSE_CYC = 8'((T_PULSE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] READ_CYC  = 8'((T_READ_NS * CLK_MHZ + 999) / 1000);
  // Longest gap rounds down; keep margin of 1 us below limit
  localparam int unsigned GAP_CYC_DEF   = (T_GAP_US - 1) * CLK_MHZ;
  localparam int unsigned PWRUP_CYC_DEF = T_PWRUP_MS * 1000 * CLK_MHZ;
  localparam int unsigned CNT_W = 20;
  // Protection command pairs, fixed constants
  localparam logic [18:0] CMD_A0 = 19'h05555;
  localparam logic [18:0] CMD_A1 = 19'h02aaa;
  localparam logic [18:0] CMD_A2 = 19'h05555;
  localparam logic [7:0]  CMD_D0 = 8'haa;
  localparam logic [7:0]  CMD_D1 = 8'h55;
  localparam logic [7:0]  CMD_D2 = 8'ha0;
  localparam logic [7:0]  ERASED = 8'hff;
  localparam int unsigned SEC_W = 11;

  typedef enum logic [5:0] {
    SFH_PWRUP = 6'h01,
    SFH_IDLE  = 6'h02,
    SFH_SETUP = 6'h04,
    SFH_PULSE = 6'h08,
    SFH_HOLD  = 6'h10,
    SFH_READ  = 6'h20
  } sfh_state_t;
endpackage

// file: rtl/sfh_host.sv
`timescale 1ns/1ps
module sfh_host
  import sfh_pkg::*;
#(
  parameter int unsigned GAP_CYC   = sfh_pkg::GAP_CYC_DEF,
  parameter int unsigned PWRUP_CYC = sfh_pkg::PWRUP_CYC_DEF
) (
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          reset,
  // User request
  input  wire logic          req_valid,
  output logic               req_ready,
  input  wire logic          req_write,
  input  wire logic          req_prefix,
  input  wire logic [18:0]   req_addr,
  input  wire logic [7:0]    req_wdata,
  output logic               rsp_valid,
  output logic [7:0]         rsp_rdata,
  output logic               load_open,
  // Flash pins
  output logic [18:0]        flash_addr,
  output logic               flash_sel_n,
  output logic               flash_drive_n,
  output logic               flash_strobe_n,
  output logic [7:0]         flash_data_o,
  output logic               flash_data_oe,
  input  wire logic [7:0]    flash_data_i
);
  import sfh_pkg::*;

  typedef struct packed {
    sfh_state_t       st;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] gap;
    logic [1:0]       pre_idx;
    logic             pre_on;
    logic             wr;
    logic [18:0]      addr;
    logic [7:0]       wdata;
    logic [7:0]       rdata;
    logic             rvalid;
    logic             open;
    logic [SEC_W-1:0] sector;
  } sfh_s_t;

  sfh_s_t s_q, s_d;

  // Prefix commands come from package constants [R26]
  function automatic logic [18:0] cmd_addr(input logic [1:0] i);
    case (i)
      2'd0:    cmd_addr = CMD_A0;
      2'd1:    cmd_addr = CMD_A1;
      default: cmd_addr = CMD_A2;
    endcase
  endfunction

  function automatic logic [7:0] cmd_data(input logic [1:0] i);
    case (i)
      2'd0:    cmd_data = CMD_D0;
      2'd1:    cmd_data = CMD_D1;
      default: cmd_data = CMD_D2;
    endcase
  endfunction

  always_comb begin
    s_d        = s_q;
    s_d.rvalid = 1'b0;
    // Device gap runs during reads too, so count whenever not writing
    if (s_q.open && !(s_q.wr && (s_q.st == SFH_SETUP || s_q.st == SFH_PULSE || s_q.st == SFH_HOLD))) begin
      if (s_q.gap == CNT_W'(GAP_CYC)) begin
        s_d.open = 1'b0; // [R6]
      end else begin
        s_d.gap = s_q.gap + 1'b1;
      end
    end
    case (s_q.st)
      SFH_PWRUP: begin
        s_d.cnt = s_q.cnt + 1'b1;
        if (s_q.cnt == CNT_W'(PWRUP_CYC)) begin // [R22]
          s_d.st = SFH_IDLE;
        end
      end
      SFH_IDLE: begin
        if (req_valid) begin
          s_d.wr      = req_write;
          s_d.addr    = req_addr;
          s_d.wdata   = req_wdata;
          s_d.cnt     = '0;
          s_d.pre_on  = req_write && req_prefix && !s_q.open; // [R16]
          s_d.pre_idx = 2'd0;
          s_d.st      = SFH_SETUP;
        end
      end
      SFH_SETUP: begin
        s_d.cnt = s_q.cnt + 1'b1;
        if (s_q.cnt + 1'b1 == CNT_W'(SETUP_CYC)) begin
          s_d.cnt = '0;
          s_d.st  = s_q.wr ? SFH_PULSE : SFH_READ;
        end
      end
      SFH_PULSE: begin
        // Pulse far longer than the noise filter
        s_d.cnt = s_q.cnt + 1'b1;
        if (s_q.cnt + 1'b1 == CNT_W'(PULSE_CYC)) begin // [R21]
          s_d.cnt = '0;
          s_d.gap = '0;
          s_d.st  = SFH_HOLD;
        end
      end
      SFH_HOLD: begin
        s_d.cnt = s_q.cnt + 1'b1;
        if (s_q.cnt + 1'b1 == CNT_W'(SETUP_CYC)) begin
          s_d.cnt  = '0;
          s_d.open = 1'b1;
          s_d.gap  = s_q.gap + CNT_W'(SETUP_CYC);
          if (s_q.pre_on) begin
            if (s_q.pre_idx == 2'd2) begin
              s_d.pre_on = 1'b0;
              s_d.sector = s_q.addr[18:8]; // [R9]
            end else begin
              s_d.pre_idx = s_q.pre_idx + 1'b1;
            end
            s_d.st = SFH_SETUP; // [R17]
          end else begin
            s_d.sector = s_q.addr[18:8]; // [R9]
            s_d.st     = SFH_IDLE;
          end
        end
      end
      SFH_READ: begin
        s_d.cnt = s_q.cnt + 1'b1;
        if (s_q.cnt + 1'b1 == CNT_W'(READ_CYC)) begin
          s_d.rdata  = flash_data_i; // [R11]
          s_d.rvalid = 1'b1;
          s_d.st     = SFH_IDLE;
        end
      end
      default: s_d.st = SFH_IDLE;
    endcase
    if (reset) begin
      s_d        = '0;
      s_d.st     = SFH_PWRUP;
    end
  end

  always_ff @(posedge clock) begin
    s_q <= s_d;
  end

  logic pulsing, writing;
  assign pulsing = s_q.st == SFH_PULSE;
  assign writing = s_q.wr && (s_q.st == SFH_SETUP || pulsing || s_q.st == SFH_HOLD);

  // Host accepts only while idle; a sector mismatch drops ready until window closes, but IDLE takes req_valid without ready
  assign req_ready = s_q.st == SFH_IDLE &&
                     !(s_q.open && req_write && req_addr[18:8] != s_q.sector); // [R9]

  always_comb begin
    flash_addr = (s_q.pre_on) ? cmd_addr(s_q.pre_idx) : s_q.addr; // [R8]
    flash_data_o = (s_q.pre_on) ? cmd_data(s_q.pre_idx) : s_q.wdata; // [R15]
  end

  // Select held through write setup/hold and READ; strobe pulses inside it
  assign flash_sel_n    = !(writing || s_q.st == SFH_READ);
  assign flash_strobe_n = !pulsing; // [R4]
  assign flash_drive_n  = !(s_q.st == SFH_READ); // [R1]
  assign flash_data_oe  = writing; // [R2]
  assign rsp_valid      = s_q.rvalid;
  assign rsp_rdata      = s_q.rdata;
  assign load_open      = s_q.open;

  property p_no_fight;
    @(posedge clock) disable iff (reset) flash_data_oe |-> flash_drive_n;
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("Drive and data out together"); // [R4]

  property p_pulse_len;
    @(posedge clock) disable iff (reset) $fell(flash_strobe_n)
      |-> !flash_strobe_n [*8] ##1 !flash_strobe_n ##1 !flash_strobe_n ##1 flash_strobe_n;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("Strobe pulse length wrong"); // [R21]

  property p_sel_in_pulse;
    @(posedge clock) disable iff (reset) !flash_strobe_n |-> !flash_sel_n && flash_drive_n;
  endproperty
  a_sel_in_pulse: assert property (p_sel_in_pulse) else $error("Strobe without select"); // [R20]

  property p_read_len;
    @(posedge clock) disable iff (reset) $fell(flash_drive_n) |-> !flash_drive_n [*8] ##5 rsp_valid;
  endproperty
  a_read_len: assert property (p_read_len) else $error("Read answer timing wrong"); // [R1]

  property p_prefix_order;
    @(posedge clock) disable iff (reset) $fell(flash_strobe_n) && s_q.pre_on && s_q.pre_idx == 2'd0
      |-> flash_addr == CMD_A0 && flash_data_o == CMD_D0;
  endproperty
  a_prefix_order: assert property (p_prefix_order) else $error("Prefix first command wrong"); // [R15]

  property p_same_sector;
    @(posedge clock) disable iff (reset) $fell(flash_strobe_n) && !s_q.pre_on && s_q.open
      |-> flash_addr[18:8] == s_q.sector;
  endproperty
  a_same_sector: assert property (p_same_sector) else $error("Sector changed mid load"); // [R9]

  property p_pwrup;
    @(posedge clock) disable iff (reset) s_q.st == SFH_PWRUP |-> flash_sel_n && !req_ready;
  endproperty
  a_pwrup: assert property (p_pwrup) else $error("Access during power-up"); // [R22]

  property p_gap;
    @(posedge clock) disable iff (reset) s_q.open |-> s_q.gap <= CNT_W'(GAP_CYC);
  endproperty
  a_gap: assert property (p_gap) else $error("Load gap exceeded"); // [R6]

  c_read:   cover property (@(posedge clock) disable iff (reset) rsp_valid);
  c_prefix: cover property (@(posedge clock) disable iff (reset) s_q.pre_on && s_q.pre_idx == 2'd2);
  c_close:  cover property (@(posedge clock) disable iff (reset) $fell(load_open));
endmodule // sfh_host

// file: verification/sfh_flash_model.sv
`timescale 1ns/1ps
module sfh_flash_model
  import sfh_pkg::*;
#(
  parameter int GAP_NS = 510,
  parameter int TWC_NS = 3000
) (
  // Host pins
  input  wire logic [18:0] flash_addr,
  input  wire logic        flash_sel_n,
  input  wire logic        flash_drive_n,
  input  wire logic        flash_strobe_n,
  input  wire logic [7:0]  flash_data_o,
  input  wire logic        flash_data_oe,
  // Resolved data bus
  output logic [7:0]       bus
);
  logic [7:0]  mem [logic [18:0]];
  logic [18:0] la;
  logic [18:0] qa [$];
  logic [7:0]  qd [$];
  logic [7:0]  lastd = '0;
  logic [7:0]  rd;
  logic        busy = 0;
  logic        guard = 0;
  logic        tog = 0;
  logic        junk = 0;
  realtime     t_rise = 0;
  logic [18:0] ca [3] = '{CMD_A0, CMD_A1, CMD_A2};
  logic [7:0]  cd [3] = '{CMD_D0, CMD_D1, CMD_D2};
  always @(negedge flash_strobe_n) if (!flash_sel_n && flash_drive_n) la = flash_addr;
  always @(posedge flash_strobe_n) if (!flash_sel_n && flash_drive_n && !busy) begin
    qa.push_back(la);
    qd.push_back(bus);
    t_rise = $realtime;
  end
  task automatic run_cycle();
    bit pre;
    pre = qa.size() >= 3;
    for (int i = 0; i < 3 && pre; i++) pre = qa[i] == ca[i] && qd[i] == cd[i];
    busy = 1;
    lastd = qd[$];
    #(TWC_NS);
    if ((pre || !guard) && qa.size() > 3 * pre) begin
      for (int i = 0; i < 256; i++) mem[{qa[$][18:8], 8'(i)}] = ERASED;
      for (int i = 3 * pre; i < qa.size(); i++) mem[qa[i]] = qd[i];
    end
    guard = guard | pre;
    qa = {};
    qd = {};
    busy = 0;
  endtask
  always #10 if (qa.size() != 0 && $realtime - t_rise > GAP_NS) run_cycle();
  always @(negedge flash_drive_n) if (busy) tog = !tog;
  // Polled lookup; a changing filler keeps a released bus from looking valid
  always #5 begin
    junk = !junk;
    rd = busy ? {~lastd[7], tog, lastd[5:0]} : mem.exists(flash_addr) ? mem[flash_addr] : ERASED;
  end
  assign bus = flash_data_oe ? flash_data_o : (!flash_sel_n && !flash_drive_n && flash_strobe_n) ? rd
             : {8{junk}} ^ 8'h5a;
endmodule  // sfh_flash_model

// file: verification/test_sector_flash_program_control.sv
`timescale 1ns/1ps
module test_sector_flash_program_control;
  import sfh_pkg::*;
  logic        clock = 0, reset = 1, req_valid = 0, req_write = 0, req_prefix = 0;
  logic [18:0] req_addr = '0, flash_addr;
  logic [7:0]  req_wdata = '0, bus, rsp_rdata, flash_data_o;
  logic        req_ready, rsp_valid, load_open, flash_sel_n, flash_drive_n, flash_strobe_n, flash_data_oe;
  int          failures = 0, checks = 0;
  always #5 clock = !clock;
  sfh_host #(.GAP_CYC(50), .PWRUP_CYC(20)) sfh_host_i (.clock, .reset, .req_valid, .req_ready, .req_write,
    .req_prefix, .req_addr, .req_wdata, .rsp_valid, .rsp_rdata, .load_open, .flash_addr, .flash_sel_n,
    .flash_drive_n, .flash_strobe_n, .flash_data_o, .flash_data_oe, .flash_data_i(bus));
  sfh_flash_model sfh_flash_model_i (.flash_addr, .flash_sel_n, .flash_drive_n, .flash_strobe_n,
    .flash_data_o, .flash_data_oe, .bus);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("failures %0d checks %0d", failures, checks);
    if (failures == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Ready is sampled at the falling edge so the take edge is known in advance
  task automatic req(input logic wr, input logic pf, input logic [18:0] a, input logic [7:0] d);
    int n = 0;
    @(negedge clock);
    {req_valid, req_write, req_prefix, req_addr, req_wdata} = {1'b1, wr, pf, a, d};
    while (req_ready !== 1'b1 && n++ < 2000) @(negedge clock);
    @(negedge clock);
    req_valid = 0;
  endtask
  task automatic rd(input logic [18:0] a, output logic [7:0] d);
    int n = 0;
    req(0, 0, a, 8'h00);
    do begin
      @(posedge clock);
      #1;
    end while (rsp_valid !== 1'b1 && n++ < 100);
    d = rsp_rdata;
  endtask
  task automatic settle(input logic [18:0] a);
    logic [7:0] p, q;
    rd(a, p);
    repeat (200) begin
      rd(a, q);
      if (q === p) break;
      p = q;
    end
  endtask
  task automatic wait_close();
    for (int n = 0; n < 40 && load_open !== 1'b1; n++) begin
      @(posedge clock);
      #1;
    end
    chk({7'h0, load_open}, 8'h01);
    for (int n = 0; n < 200 && load_open === 1'b1; n++) begin
      @(posedge clock);
      #1;
    end
    chk({7'h0, load_open}, 8'h00);
  endtask
  task automatic s_prog();
    logic [7:0] a, b;
    rd(19'h01234, a);
    chk(a, ERASED);
    req(1, 0, 19'h00305, 8'h35);
    req(1, 0, 19'h00301, 8'hc3);
    wait_close();
    rd(19'h00301, a);
    rd(19'h00301, b);
    chk({6'h0, a[7], a[6] ^ b[6]}, 8'h01);
    settle(19'h00301);
    rd(19'h00305, a);
    chk(a, 8'h35);
    rd(19'h00301, a);
    chk(a, 8'hc3);
    rd(19'h00300, a);
    chk(a, ERASED);
    req(1, 0, 19'h00300, 8'h00);
    wait_close();
    settle(19'h00300);
    rd(19'h00305, a);
    chk(a, ERASED);
    rd(19'h00300, a);
    chk(a, 8'h00);
  endtask
  task automatic s_guard();
    logic [7:0] a;
    req(1, 1, 19'h00510, 8'h77);
    wait_close();
    settle(19'h00510);
    rd(19'h00510, a);
    chk(a, 8'h77);
    req(1, 0, 19'h00601, 8'h11);
    wait_close();
    rd(19'h00601, a);
    chk({7'h0, a[7]}, 8'h01);
    settle(19'h00601);
    rd(19'h00601, a);
    chk(a, ERASED);
    req(1, 1, 19'h00510, 8'h99);
    wait_close();
    settle(19'h00510);
    rd(19'h00510, a);
    chk(a, 8'h99);
  endtask
  initial begin
    repeat (12) @(negedge clock);
    reset = 0;
    s_prog();
    s_guard();
    complete_run();
  end
  initial begin
    #200us;
    failures++;
    complete_run();
  end
endmodule  // test_sector_flash_program_control
